// ===== hw/sep_defs.vh
// Constants for the two-wire serial memory slave.
`ifndef SEP_DEFS_VH
`define SEP_DEFS_VH
// Device-type prefix of the slave address byte; the value is arbitrary.
`define SEP_TYPE_PREFIX 4'h6
`define SEP_PAGE_BITS 5
`define SEP_WR_TIME_MS 10
`define SEP_CLK_HZ 100000000
`define SEP_WR_CYCLES ((`SEP_WR_TIME_MS * (`SEP_CLK_HZ / 1000)))
`define SEP_BIT_LAST 4'h8
`define SEP_BIT_ACK 4'h9
`define SEP_ABITS_64K 13
`define SEP_ABITS_32K 12
`endif

// ===== hw/sep_eeprom_slave.v
// Two-wire serial memory slave with page write buffer, write protection and sequential read.
`timescale 1ns/1ps
`default_nettype none
`include "sep_defs.vh"
module sep_eeprom_slave #(
   parameter ABITS = `SEP_ABITS_64K,
   parameter WR_CYCLES = `SEP_WR_CYCLES
) (
   input wire i_clk_sys,
   input wire i_nrst,
   input wire i_scl,
   input wire i_sda,
   output wire o_sda,
   output wire o_sda_oe_n,
   input wire i_select_pin_bit0,
   input wire i_select_pin_bit1,
   input wire i_select_pin_bit2,
   input wire i_wp,
   output reg o_busy
);
   localparam DEPTH = 1 << ABITS;
   localparam PB = `SEP_PAGE_BITS;
   localparam PSIZE = 1 << PB;
   // Bus phases.
   localparam ST_IDLE = 3'd0;
   localparam ST_DEVADR = 3'd1;
   localparam ST_ADRHI = 3'd2;
   localparam ST_ADRLO = 3'd3;
   localparam ST_WDATA = 3'd4;
   localparam ST_RDATA = 3'd5;
   localparam ST_WAITSTOP = 3'd6;

   // How the engine is organised.
   // Every bus pin is sampled by the system clock through two flip-flops.
   // Clock and data edges are judged between the second and third stage.
   // Start and stop are therefore seen three system clocks after the wire moves.
   // Data bits are captured on a rising bus clock, as the bus allows data to move only while it is low.
   // Outgoing bits and acknowledges change on the falling bus clock.
   // The change lands three system clocks after the fall, well inside the low phase.
   // This gives a built-in data hold time after the master lowers the clock.
   // The bus clock must stay low and high for at least four system clocks each.
   // A faster bus would let an edge slip between two samples and be lost.
   // While sending, the shifter holds the outgoing byte and never captures the wire.
   // While receiving, the same shifter collects the incoming byte.
   // The ninth bus clock of each byte is the acknowledge phase.
   // In it the receiver pulls the data line low and the sender lets go.
   // Received data goes to a page buffer first and never straight to the array.
   // The array is only written once the master has closed the write with a stop.
   // A repeated start in the middle of a write throws the buffered bytes away.
   // The programming time is a plain cycle count; the bench shortens it.
   // During programming the engine is held idle, so nothing is acknowledged.
   // Protection is judged once, on the address given before the first data byte.
   // A write that starts in the protected area is refused as a whole.
   // The trade-off is simpler logic against a write that crosses the boundary.
   // The array has no reset; its contents are unknown until written.

   // Storage array and the page buffer that collects one write.
   reg [7:0] mem [0:DEPTH-1];
   reg [7:0] page_buf [0:PSIZE-1];
   reg [PSIZE-1:0] page_vld_r;

   // Two-flop synchronisers; only the second stage and later are read.
   reg [2:0] scl_s;
   reg [2:0] sda_s;
   reg [1:0] sel_s [0:2];
   reg [1:0] wp_s;
   wire scl_rise = scl_s[1] & ~scl_s[2];
   wire scl_fall = ~scl_s[1] & scl_s[2];
   wire start_det = scl_s[1] & scl_s[2] & ~sda_s[1] & sda_s[2];
   wire stop_det = scl_s[1] & scl_s[2] & sda_s[1] & ~sda_s[2];

   // Protocol state, shifter and address counter.
   reg [2:0] st_r;
   reg [3:0] bitc_r;
   reg [7:0] shf_r;
   reg rw_r;
   reg ack_phase_r;
   reg sda_low_r;
   reg [ABITS-1:0] ptr_r;
   reg [ABITS-1:0] page_base_r;
   reg hi_byte_r;
   reg wr_pend_r;
   reg prot_r;
   // Programming timer.
   reg [31:0] wcnt_r;
   reg prog_r;
   integer i;

   // Open-drain data pin: the value is always low and only the enable moves.
   assign o_sda = 1'b0;
   assign o_sda_oe_n = ~sda_low_r;

   // Bottom quarter of the array is protected when the pin is high.
   function is_prot;
      input [ABITS-1:0] a;
      begin
         is_prot = (a[ABITS-1:ABITS-2] == 2'b00);
      end
   endfunction

   // Pin synchronisers; the bus lines reset to their idle high level so no false edge follows reset.
   always @(posedge i_clk_sys)
   begin
      if (!i_nrst)
      begin
         scl_s <= 3'b111;
         sda_s <= 3'b111;
         wp_s <= 2'b00;
         for (i = 0; i < 3; i = i + 1)
            sel_s[i] <= 2'b00;
      end
      else
      begin
         scl_s <= {scl_s[1:0], i_scl};
         sda_s <= {sda_s[1:0], i_sda};
         wp_s <= {wp_s[0], i_wp};
         sel_s[0] <= {sel_s[0][0], i_select_pin_bit0};
         sel_s[1] <= {sel_s[1][0], i_select_pin_bit1};
         sel_s[2] <= {sel_s[2][0], i_select_pin_bit2};
      end
   end

   // Pins read as zero when floating, so an unconnected select compares as zero.
   wire [2:0] sel_v = {sel_s[2][1], sel_s[1][1], sel_s[0][1]};

   // Self-timed programming; the bus is ignored and data released until done.
   always @(posedge i_clk_sys)
   begin
      if (!i_nrst)
      begin
         prog_r <= 1'b0;
         wcnt_r <= 32'h0000_0000;
         o_busy <= 1'b0;
      end
      else if (prog_r)
      begin
         if (wcnt_r == 32'h0000_0000)
         begin
            prog_r <= 1'b0;
            o_busy <= 1'b0;
            for (i = 0; i < PSIZE; i = i + 1)
               if (page_vld_r[i])
                  mem[page_base_r | i[ABITS-1:0]] <= page_buf[i];
         end
         else
            wcnt_r <= wcnt_r - 32'h0000_0001;
      end
      else if (wr_pend_r && stop_det)
      begin
         prog_r <= 1'b1;
         o_busy <= 1'b1;
         wcnt_r <= WR_CYCLES - 1;
      end
   end

   // Bus protocol engine.
   always @(posedge i_clk_sys)
   begin
      if (!i_nrst)
      begin
         st_r <= ST_IDLE;
         bitc_r <= 4'h0;
         shf_r <= 8'h00;
         rw_r <= 1'b0;
         ack_phase_r <= 1'b0;
         sda_low_r <= 1'b0;
         ptr_r <= {ABITS{1'b0}};
         page_base_r <= {ABITS{1'b0}};
         hi_byte_r <= 1'b0;
         wr_pend_r <= 1'b0;
         prot_r <= 1'b0;
         page_vld_r <= {PSIZE{1'b0}};
      end
      else if (prog_r)
      begin
         st_r <= ST_IDLE;
         sda_low_r <= 1'b0;
         wr_pend_r <= 1'b0;
      end
      else if (stop_det)
      begin
         st_r <= ST_IDLE;
         sda_low_r <= 1'b0;
      end
      else if (start_det)
      begin
         st_r <= ST_DEVADR;
         bitc_r <= 4'h0;
         ack_phase_r <= 1'b0;
         sda_low_r <= 1'b0;
         wr_pend_r <= 1'b0; // Repeated start abandons an unfinished write.
      end
      else if (st_r != ST_IDLE && st_r != ST_WAITSTOP)
      begin
         if (scl_rise && !ack_phase_r)
         begin
            // While sending, the shifter holds outgoing bits, so only receive phases capture.
            if (st_r != ST_RDATA)
               shf_r <= {shf_r[6:0], sda_s[1]};
            bitc_r <= bitc_r + 4'h1;
         end
         else if (scl_rise && ack_phase_r && st_r == ST_RDATA)
         begin
            if (sda_s[1])
               st_r <= ST_WAITSTOP;
         end
         else if (scl_fall && !ack_phase_r && st_r == ST_RDATA && bitc_r != `SEP_BIT_LAST)
         begin
            sda_low_r <= ~shf_r[7];
            shf_r <= {shf_r[6:0], 1'b0};
         end
         else if (scl_fall && !ack_phase_r && bitc_r == `SEP_BIT_LAST)
         begin
            // Ninth clock: receiver acknowledges, transmitter releases.
            ack_phase_r <= 1'b1;
            bitc_r <= 4'h0;
            sda_low_r <= 1'b0;
            case (st_r)
               ST_DEVADR:
               begin
                  if (shf_r[7:4] == `SEP_TYPE_PREFIX && shf_r[3:1] == sel_v)
                  begin
                     sda_low_r <= 1'b1;
                     rw_r <= shf_r[0];
                  end
                  else
                     st_r <= ST_WAITSTOP;
               end
               ST_ADRHI:
               begin
                  sda_low_r <= 1'b1;
                  // Only the bits that fit the array are kept from the high byte.
                  ptr_r <= {shf_r[ABITS-9:0], ptr_r[7:0]};
               end
               ST_ADRLO:
               begin
                  sda_low_r <= 1'b1;
                  ptr_r <= {ptr_r[ABITS-1:8], shf_r};
               end
               ST_WDATA:
               begin
                  if (prot_r)
                     st_r <= ST_WAITSTOP;
                  else
                  begin
                     sda_low_r <= 1'b1;
                     page_buf[ptr_r[PB-1:0]] <= shf_r;
                     page_vld_r[ptr_r[PB-1:0]] <= 1'b1;
                     wr_pend_r <= 1'b1;
                     ptr_r[PB-1:0] <= ptr_r[PB-1:0] + 1'b1;
                  end
               end
               ST_RDATA:
               begin
                  // Let go of the line so the master can answer; its answer decides what follows.
                  st_r <= ST_RDATA;
               end
               default:
                  st_r <= ST_WAITSTOP;
            endcase
         end
         else if (scl_fall && ack_phase_r)
         begin
            // End of the ninth clock: move to the next byte.
            ack_phase_r <= 1'b0;
            sda_low_r <= 1'b0;
            case (st_r)
               ST_DEVADR:
               begin
                  if (rw_r)
                  begin
                     st_r <= ST_RDATA;
                     sda_low_r <= ~mem[ptr_r][7];
                     shf_r <= {mem[ptr_r][6:0], 1'b0};
                     bitc_r <= 4'h0;
                     ptr_r <= ptr_r + 1'b1;
                  end
                  else
                     st_r <= ST_ADRHI;
               end
               ST_ADRHI:
                  st_r <= ST_ADRLO;
               ST_ADRLO:
               begin
                  st_r <= ST_WDATA;
                  page_base_r <= {ptr_r[ABITS-1:PB], {PB{1'b0}}};
                  page_vld_r <= {PSIZE{1'b0}};
                  prot_r <= wp_s[1] & is_prot(ptr_r);
               end
               ST_WDATA:
                  st_r <= ST_WDATA;
               ST_RDATA:
               begin
                  sda_low_r <= ~mem[ptr_r][7];
                  shf_r <= {mem[ptr_r][6:0], 1'b0};
                  ptr_r <= ptr_r + 1'b1;
               end
               default:
                  st_r <= ST_IDLE;
            endcase
         end
      end
   end
endmodule
`default_nettype wire

// ===== test/sep_eeprom_slave_assertions.sv
// Port checks for the serial memory slave.
`timescale 1ns/1ps
`default_nettype none
module sep_eeprom_slave_chk #(parameter WR_CYCLES = 200) (
   input wire logic i_clk_sys,
   input wire logic i_nrst,
   input wire logic i_scl,
   input wire logic i_sda,
   input wire logic o_sda,
   input wire logic o_sda_oe_n,
   input wire logic o_busy
);
   logic [31:0] busy_cnt_r;
   wire [31:0] busy_cnt_nxt = o_busy ? busy_cnt_r + 32'h0000_0001 : 32'h0000_0000;
   // Counts the write cycle, so its length is judged in the cycle it ends.
   always @(posedge i_clk_sys)
   begin
      busy_cnt_r <= i_nrst ? busy_cnt_nxt : 32'h0000_0000;
   end
   default clocking @(posedge i_clk_sys); endclocking
   default disable iff (!i_nrst);
   // A start as seen on the wire.
   sequence s_start;
      i_scl && $fell(i_sda);
   endsequence
   chk_reset_idle: assert property (disable iff (1'b0) !i_nrst |=> o_sda_oe_n && !o_busy)
      else $error("reset state wrong");
   chk_open_drain: assert property (o_sda == 1'b0)
      else $error("data pin not open drain");
   chk_busy_quiet: assert property (o_busy |-> o_sda_oe_n)
      else $error("drive while busy");
   chk_high_stable: assert property (i_scl |-> $stable(o_sda_oe_n))
      else $error("drive moved with clock high");
   chk_ack_hold: assert property ($fell(o_sda_oe_n) |=> !o_sda_oe_n [*4])
      else $error("drive too short");
   chk_busy_stop: assert property ($rose(o_busy) |-> i_scl && i_sda)
      else $error("write cycle without stop");
   chk_busy_length: assert property (!o_busy && busy_cnt_r != 32'h0000_0000 |-> busy_cnt_r == WR_CYCLES)
      else $error("write cycle length");
   chk_start_release: assert property (s_start |=> o_sda_oe_n [*3])
      else $error("drive after start");
endmodule
bind sep_eeprom_slave sep_eeprom_slave_chk #(.WR_CYCLES(WR_CYCLES)) sep_eeprom_slave_chk_inst (
   .i_clk_sys(i_clk_sys), .i_nrst(i_nrst), .i_scl(i_scl), .i_sda(i_sda), .o_sda(o_sda),
   .o_sda_oe_n(o_sda_oe_n), .o_busy(o_busy));
`default_nettype wire

// ===== test/sep_bus_master.sv
// Behavioural two-wire bus master; the clock stands high between frames.
`timescale 1ns/1ps
`default_nettype none
module sep_bus_master (
   output logic o_scl,
   output logic o_sda,
   input wire logic i_sda_wire
);
   // Both lines start released to the pull-up level.
   initial
   begin
      o_scl = 1'b1;
      o_sda = 1'b1;
   end
   // One quarter of the 125 ns bus period, then new line levels.
   task automatic step(input logic sd, input logic sc);
      #31.25;
      o_sda = sd;
      o_scl = sc;
   endtask
   // One clock pulse; data moves only while the clock is low.
   task automatic xfer(input logic b, output logic s);
      step(b, 1'b0);
      step(b, 1'b1);
      step(b, 1'b1);
      s = i_sda_wire;
      step(b, 1'b0);
   endtask
   // Start from idle, or repeated start from the low clock phase.
   task automatic start();
      step(1'b1, 1'b0);
      step(1'b1, 1'b1);
      step(1'b0, 1'b1);
      step(1'b0, 1'b0);
   endtask
   // Stop, then free bus time before anything new begins.
   task automatic stop();
      step(1'b0, 1'b0);
      step(1'b0, 1'b1);
      step(1'b1, 1'b1);
      step(1'b1, 1'b1);
   endtask
   // Byte out MSB first, then the receiver's answer in the ninth pulse.
   task automatic wbyte(input logic [7:0] d, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--)
         xfer(d[i], s);
      xfer(1'b1, s);
      ack = !s;
   endtask
   // Byte in with data released, then our acknowledge or its absence.
   task automatic rbyte(input logic ack, output logic [7:0] d);
      logic s;
      for (int i = 7; i >= 0; i--)
         xfer(1'b1, d[i]);
      xfer(!ack, s);
   endtask
endmodule
`default_nettype wire

// ===== test/tb_sep_eeprom_slave.sv
// Self-checking bench for the serial memory slave.
`timescale 1ns/1ps
`default_nettype none
`include "sep_defs.vh"
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin err_count++; $display("ERROR %0t got %h want %h", $time, (a), (b)); end end
module tb_sep_eeprom_slave;
   localparam logic [2:0] SEL = 3'b101;
   localparam logic [7:0] DEV_W = {`SEP_TYPE_PREFIX, SEL, 1'b0};
   logic i_clk_sys = 1'b0, i_nrst = 1'b0, i_wp = 1'b0, ack;
   wire m_scl, m_sda, oe_n, sda_out, busy;
   wire sda_w = m_sda & (oe_n | sda_out);
   int err_count = 0, samples_checked = 0;
   logic [7:0] exp_mem [0:8191];
   logic [7:0] d;
   logic [12:0] cnt_exp;
   sep_eeprom_slave #(.ABITS(13), .WR_CYCLES(200)) sep_eeprom_slave_inst (.i_clk_sys(i_clk_sys),
      .i_nrst(i_nrst), .i_scl(m_scl), .i_sda(sda_w), .o_sda(sda_out), .o_sda_oe_n(oe_n), .i_wp(i_wp),
      .i_select_pin_bit0(SEL[0]), .i_select_pin_bit1(SEL[1]), .i_select_pin_bit2(SEL[2]), .o_busy(busy));
   sep_bus_master sep_bus_master_inst (.o_scl(m_scl), .o_sda(m_sda), .i_sda_wire(sda_w));
   // Free-running system clock.
   initial
   begin
      forever #5 i_clk_sys = ~i_clk_sys;
   end
   task automatic end_sim();
      $display("checks %0d mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   // Device address byte; the answer is compared with want.
   task automatic dev(input logic [7:0] b, input logic want);
      sep_bus_master_inst.start();
      sep_bus_master_inst.wbyte(b, ack);
      `CHK(ack, want)
   endtask
   // Write address and both memory address bytes; the counter drops high bits.
   task automatic addr(input logic [15:0] a);
      dev(DEV_W, 1'b1);
      sep_bus_master_inst.wbyte(a[15:8], ack);
      `CHK(ack, 1'b1)
      sep_bus_master_inst.wbyte(a[7:0], ack);
      `CHK(ack, 1'b1)
      cnt_exp = a[12:0];
   endtask
   // Writes n bytes; when accepted, polls through the write cycle.
   task automatic wr(input logic [15:0] a, input int n, input logic [7:0] base, input logic ok);
      addr(a);
      for (int i = 0; i < n; i++)
      begin
         sep_bus_master_inst.wbyte(base + 8'(i), ack);
         `CHK(ack, ok)
         if (ok)
            exp_mem[{a[12:5], a[4:0] + 5'(i)}] = base + 8'(i);
      end
      sep_bus_master_inst.stop();
      `CHK(busy, ok)
      if (ok)
      begin
         dev(DEV_W, 1'b0);
         sep_bus_master_inst.stop();
         for (int k = 0; k < 400 && busy; k++)
            @(posedge i_clk_sys);
         `CHK(busy, 1'b0)
         dev(DEV_W, 1'b1);
         sep_bus_master_inst.stop();
      end
   endtask
   // Random read of n bytes, or current-address read when cur is set.
   task automatic rd(input logic [15:0] a, input int n, input logic cur);
      if (!cur)
         addr(a);
      dev(DEV_W | 8'h01, 1'b1);
      for (int i = 0; i < n; i++)
      begin
         sep_bus_master_inst.rbyte(i < n - 1, d);
         `CHK(d, exp_mem[cnt_exp])
         cnt_exp = cnt_exp + 13'h0001;
      end
      sep_bus_master_inst.stop();
   endtask
   // Other select bits go unanswered; page overrun wraps; read wraps to zero.
   task automatic s_page();
      dev({`SEP_TYPE_PREFIX, SEL ^ 3'b011, 1'b0}, 1'b0);
      sep_bus_master_inst.stop();
      wr(16'hE000, 1, 8'hC3, 1'b1);
      wr(16'h1FE0, 34, 8'h10, 1'b1);
      rd(16'h1FE0, 33, 1'b0);
   endtask
   // Protected bottom quarter refuses data; the first free location still writes.
   task automatic s_protect();
      wr(16'h07FF, 1, 8'h5A, 1'b1);
      @(posedge i_clk_sys) i_wp <= 1'b1;
      wr(16'h07FF, 1, 8'hA5, 1'b0);
      wr(16'h0800, 1, 8'h77, 1'b1);
      rd(16'h07FF, 1, 1'b0);
      rd(16'h0000, 1, 1'b1);
   endtask
   // Main sequence: reset for three cycles, then the scenarios.
   initial
   begin
      repeat (3) @(posedge i_clk_sys);
      i_nrst <= 1'b1;
      repeat (3) @(posedge i_clk_sys);
      s_page();
      s_protect();
      end_sim();
   end
   // Watchdog well beyond the expected run of about 126 us.
   initial
   begin
      #600_000;
      err_count++;
      end_sim();
   end
endmodule
`default_nettype wire
